//--- acs_defs.svh
// Constant definitions for the converter control-word sequencer
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// =============================================
// Serial frame geometry
`define ACS_WORD_BITS 16
`define ACS_BITCNT_W 5
`define ACS_WORD_FULL 5'h10
`define ACS_DATA_BITS 10
`define ACS_LEAD_BITS 5'h06
`define ACS_PAD_ZERO 6'h00

// =============================================
// Start-up and scan sequencing
`define ACS_STARTUP_FRAMES 2'h2
`define ACS_CHAN_W 3
`define ACS_POS_FIRST 3'h0
`define ACS_POS_STEP 3'h1
`define ACS_SEQ_ASC 2'h0
`define ACS_SEQ_ODD 2'h1
`define ACS_SEQ_EVEN 2'h2
`define ACS_SEQ_DESC 2'h3

// =============================================
// Reset value and result buffer depth
`define ACS_WORD_RESET 16'h0000
`define ACS_BUF_DEPTH 2

`endif

//--- acs_pkg.sv
// Types shared by the converter control-word sequencer
package acs_pkg;

	// =============================================
	// Control word layout, most significant field first
	typedef struct packed {
		logic softPowerdown;
		logic readBack;
		logic [1:0] selfTest;
		logic lowSpeed;
		logic scanEnable;
		logic [2:0] chanField;
		logic refSourceSelect;
		logic refLevelSelect;
		logic autoPowerdownEnable;
		logic linearityOptimizer;
		logic [2:0] reservedBits;
	} acs_ctrl_t;

	// =============================================
	// Frame state
	typedef enum logic [1:0] {
		ACS_IDLE = 2'b01,
		ACS_FRAME = 2'b10
	} acs_state_t;

endpackage

//--- acs_sequencer.sv
// Control-word sequencer of an eight-channel serial sampling converter
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"

// =============================================
// Two-entry result buffer
module acs_buf #(
	parameter int W = `ACS_DATA_BITS,
	parameter int DEPTH = `ACS_BUF_DEPTH
) (
	input wire logic clk,
	input wire logic rstN,
	input wire logic inValid,
	input wire logic [W-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [W-1:0] outData,
	input wire logic outReady
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CDEPTH = CW'(DEPTH);
	localparam logic [AW-1:0] ALAST = AW'(DEPTH - 1);
	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
	logic [CW-1:0] count_ff, nxt_count;
	logic inReady_ff, nxt_inReady;
	logic push, pop;

	assign push = inValid && inReady_ff;
	assign pop = outReady && (count_ff != '0);
	assign inReady = inReady_ff;
	assign outValid = (count_ff != '0);
	assign outData = mem_ff[rdPtr_ff];

	always_comb begin
		nxt_wrPtr = wrPtr_ff;
		nxt_rdPtr = rdPtr_ff;
		nxt_count = count_ff;
		if (push) begin
			nxt_wrPtr = (wrPtr_ff == ALAST) ? '0 : wrPtr_ff + AW'(1);
		end
		if (pop) begin
			nxt_rdPtr = (rdPtr_ff == ALAST) ? '0 : rdPtr_ff + AW'(1);
		end
		if (push && !pop) begin
			nxt_count = count_ff + CW'(1);
		end else if (pop && !push) begin
			nxt_count = count_ff - CW'(1);
		end
		nxt_inReady = (nxt_count != CDEPTH);
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
			inReady_ff <= 1'b0;
		end else begin
			wrPtr_ff <= nxt_wrPtr;
			rdPtr_ff <= nxt_rdPtr;
			count_ff <= nxt_count;
			inReady_ff <= nxt_inReady;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wrPtr_ff] <= inData;
		end
	end
endmodule

// =============================================
// Sequencer top
module acs_sequencer (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic csN,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataOutOe,
	output logic sampleReq,
	output logic [`ACS_CHAN_W-1:0] sampleChan,
	output logic frameValid,
	output acs_pkg::acs_ctrl_t settings,
	input wire logic adcValid,
	input wire logic [`ACS_DATA_BITS-1:0] adcData,
	output logic adcReady
);
	import acs_pkg::*;

	// =============================================
	// Reset release and pin synchronisers
	logic [1:0] rstSync_ff;
	logic rstN;
	logic [1:0] sclkSync_ff, csSync_ff, sdiSync_ff;
	logic sclkD_ff, csD_ff;
	logic sclkRise, sclkFall, frameStart, frameEnd;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync_ff <= 2'h0;
		end else begin
			rstSync_ff <= {rstSync_ff[0], 1'b1};
		end
	end
	assign rstN = rstSync_ff[1];

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			sclkSync_ff <= 2'h0;
			csSync_ff <= 2'h3;
			sdiSync_ff <= 2'h0;
			sclkD_ff <= 1'b0;
			csD_ff <= 1'b1;
		end else begin
			sclkSync_ff <= {sclkSync_ff[0], sclk};
			csSync_ff <= {csSync_ff[0], csN};
			sdiSync_ff <= {sdiSync_ff[0], serialDataIn};
			sclkD_ff <= sclkSync_ff[1];
			csD_ff <= csSync_ff[1];
		end
	end
	assign sclkRise = sclkSync_ff[1] && !sclkD_ff;
	assign sclkFall = !sclkSync_ff[1] && sclkD_ff;
	assign frameStart = !csSync_ff[1] && csD_ff;
	assign frameEnd = csSync_ff[1] && !csD_ff;

	// =============================================
	// Result buffer between converter and shifter
	logic bufValid, bufPop;
	logic [`ACS_DATA_BITS-1:0] bufData;

	acs_buf #(.W(`ACS_DATA_BITS), .DEPTH(`ACS_BUF_DEPTH)) resultBuf (
		.clk(clk),
		.rstN(rstN),
		.inValid(adcValid),
		.inData(adcData),
		.inReady(adcReady),
		.outValid(bufValid),
		.outData(bufData),
		.outReady(bufPop)
	);

	// =============================================
	// Frame state, sequencing and shifters
	acs_state_t state_ff, nxt_state;
	logic [`ACS_WORD_BITS-1:0] rxShift_ff, nxt_rxShift, txShift_ff, nxt_txShift, txBase;
	logic [`ACS_BITCNT_W-1:0] rxCnt_ff, nxt_rxCnt, txCnt_ff, nxt_txCnt;
	acs_ctrl_t pend_ff, nxt_pend, settings_ff, nxt_settings;
	logic [1:0] startCnt_ff, nxt_startCnt;
	logic pdLast_ff, nxt_pdLast, scanLast_ff, nxt_scanLast;
	logic [1:0] lastSeq_ff, nxt_lastSeq;
	logic [`ACS_CHAN_W-1:0] scanPos_ff, nxt_scanPos, pos, chan, sampleChan_ff, nxt_sampleChan;
	logic sampleReq_ff, nxt_sampleReq, frameValid_ff, nxt_frameValid;
	logic serialDataOut_ff, nxt_serialDataOut, oe_ff, nxt_oe;
	logic goodFrame, scanStart;

	function automatic logic [`ACS_CHAN_W-1:0] seqChan(input logic [1:0] seq,
		input logic [`ACS_CHAN_W-1:0] p);
		case (seq)
			`ACS_SEQ_ASC: seqChan = p;
			`ACS_SEQ_ODD: seqChan = {p[1:0], 1'b1};
			`ACS_SEQ_EVEN: seqChan = {p[1:0], 1'b0};
			`ACS_SEQ_DESC: seqChan = ~p;
			default: seqChan = p;
		endcase
	endfunction

	// Valid only after start-up and outside power-down and its recovery
	assign goodFrame = (startCnt_ff == `ACS_STARTUP_FRAMES) && !pend_ff.softPowerdown
		&& !pdLast_ff;
	assign scanStart = pend_ff.chanField[0] || !scanLast_ff
		|| (pend_ff.chanField[2:1] != lastSeq_ff);
	assign pos = scanStart ? `ACS_POS_FIRST : scanPos_ff;
	assign chan = pend_ff.scanEnable ? seqChan(pend_ff.chanField[2:1], pos)
		: pend_ff.chanField;
	assign txBase = (txCnt_ff == `ACS_LEAD_BITS)
		? ((frameValid_ff && bufValid) ? {bufData, `ACS_PAD_ZERO} : `ACS_WORD_RESET)
		: txShift_ff;
	assign bufPop = (state_ff == ACS_FRAME) && sclkFall && (txCnt_ff == `ACS_LEAD_BITS);

	always_comb begin
		nxt_state = state_ff;
		nxt_rxShift = rxShift_ff;
		nxt_rxCnt = rxCnt_ff;
		nxt_txShift = txShift_ff;
		nxt_txCnt = txCnt_ff;
		nxt_pend = pend_ff;
		nxt_settings = settings_ff;
		nxt_startCnt = startCnt_ff;
		nxt_pdLast = pdLast_ff;
		nxt_scanLast = scanLast_ff;
		nxt_lastSeq = lastSeq_ff;
		nxt_scanPos = scanPos_ff;
		nxt_sampleChan = sampleChan_ff;
		nxt_sampleReq = 1'b0;
		nxt_frameValid = frameValid_ff;
		nxt_serialDataOut = serialDataOut_ff;
		nxt_oe = oe_ff;
		case (state_ff)
			ACS_IDLE: begin
				nxt_oe = 1'b0;
				if (frameStart) begin
					nxt_state = ACS_FRAME;
					nxt_oe = 1'b1;
					nxt_rxCnt = '0;
					nxt_txCnt = '0;
					nxt_txShift = `ACS_WORD_RESET;
					nxt_serialDataOut = 1'b0;
					nxt_settings = pend_ff;
					nxt_frameValid = goodFrame;
					nxt_sampleReq = goodFrame;
					nxt_sampleChan = chan;
					nxt_pdLast = pend_ff.softPowerdown;
					if (startCnt_ff != `ACS_STARTUP_FRAMES) begin
						nxt_startCnt = startCnt_ff + 2'h1;
					end
					nxt_scanLast = pend_ff.scanEnable;
					nxt_lastSeq = pend_ff.chanField[2:1];
					if (pend_ff.scanEnable && (goodFrame || pend_ff.softPowerdown)) begin
						nxt_scanPos = pos + `ACS_POS_STEP;
					end else if (pend_ff.scanEnable) begin
						nxt_scanPos = pos;
					end
				end
			end
			ACS_FRAME: begin
				if (frameEnd) begin
					nxt_state = ACS_IDLE;
					nxt_oe = 1'b0;
					nxt_serialDataOut = 1'b0;
					if (rxCnt_ff == `ACS_WORD_FULL) begin
						nxt_pend = acs_ctrl_t'(rxShift_ff);
					end
				end else begin
					if (sclkRise && rxCnt_ff != `ACS_WORD_FULL) begin
						nxt_rxShift = {rxShift_ff[`ACS_WORD_BITS-2:0], sdiSync_ff[1]};
						nxt_rxCnt = rxCnt_ff + `ACS_BITCNT_W'(1);
					end
					if (sclkFall) begin
						nxt_serialDataOut = txBase[`ACS_WORD_BITS-1];
						nxt_txShift = {txBase[`ACS_WORD_BITS-2:0], 1'b0};
						if (txCnt_ff != `ACS_WORD_FULL) begin
							nxt_txCnt = txCnt_ff + `ACS_BITCNT_W'(1);
						end
					end
				end
			end
			default: begin
				nxt_state = ACS_IDLE;
				nxt_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_ff <= ACS_IDLE;
			rxShift_ff <= `ACS_WORD_RESET;
			rxCnt_ff <= '0;
			txShift_ff <= `ACS_WORD_RESET;
			txCnt_ff <= '0;
			pend_ff <= acs_ctrl_t'(`ACS_WORD_RESET);
			settings_ff <= acs_ctrl_t'(`ACS_WORD_RESET);
			startCnt_ff <= 2'h0;
			pdLast_ff <= 1'b0;
			scanLast_ff <= 1'b0;
			lastSeq_ff <= `ACS_SEQ_ASC;
			scanPos_ff <= `ACS_POS_FIRST;
			sampleChan_ff <= `ACS_POS_FIRST;
			sampleReq_ff <= 1'b0;
			frameValid_ff <= 1'b0;
			serialDataOut_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			rxShift_ff <= nxt_rxShift;
			rxCnt_ff <= nxt_rxCnt;
			txShift_ff <= nxt_txShift;
			txCnt_ff <= nxt_txCnt;
			pend_ff <= nxt_pend;
			settings_ff <= nxt_settings;
			startCnt_ff <= nxt_startCnt;
			pdLast_ff <= nxt_pdLast;
			scanLast_ff <= nxt_scanLast;
			lastSeq_ff <= nxt_lastSeq;
			scanPos_ff <= nxt_scanPos;
			sampleChan_ff <= nxt_sampleChan;
			sampleReq_ff <= nxt_sampleReq;
			frameValid_ff <= nxt_frameValid;
			serialDataOut_ff <= nxt_serialDataOut;
			oe_ff <= nxt_oe;
		end
	end

	assign serialDataOut = serialDataOut_ff;
	assign serialDataOutOe = oe_ff;
	assign sampleReq = sampleReq_ff;
	assign sampleChan = sampleChan_ff;
	assign frameValid = frameValid_ff;
	assign settings = settings_ff;

	// =============================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	logic startIdle;
	assign startIdle = frameStart && (state_ff == ACS_IDLE);

	sequence s_sampled;
		sampleReq_ff && frameValid_ff;
	endsequence
	sequence s_dead;
		!sampleReq_ff && !frameValid_ff;
	endsequence

	property p_settings_delay;
		startIdle |=> (settings_ff == $past(pend_ff));
	endproperty
	a_settings_delay: assert property (p_settings_delay) else $error("settings not delayed");

	property p_startup;
		startIdle && (startCnt_ff != `ACS_STARTUP_FRAMES) |=> s_dead;
	endproperty
	a_startup: assert property (p_startup) else $error("start-up frame valid");

	property p_valid_sample;
		startIdle && goodFrame |=> s_sampled ##1 !sampleReq_ff;
	endproperty
	a_valid_sample: assert property (p_valid_sample) else $error("sample pulse wrong");

	property p_powerdown;
		startIdle && pend_ff.softPowerdown |=> s_dead;
	endproperty
	a_powerdown: assert property (p_powerdown) else $error("power-down frame sampled");

	property p_recovery;
		startIdle && pdLast_ff |=> s_dead;
	endproperty
	a_recovery: assert property (p_recovery) else $error("recovery frame sampled");

	property p_direct;
		startIdle && !pend_ff.scanEnable |=> (sampleChan_ff == $past(pend_ff.chanField));
	endproperty
	a_direct: assert property (p_direct) else $error("direct channel wrong");

	property p_scan_reset;
		startIdle && pend_ff.scanEnable && pend_ff.chanField[0]
			|=> (sampleChan_ff == seqChan(lastSeq_ff, `ACS_POS_FIRST))
			&& (scanPos_ff == (($past(goodFrame) || $past(pend_ff.softPowerdown))
			? `ACS_POS_STEP : `ACS_POS_FIRST));
	endproperty
	a_scan_reset: assert property (p_scan_reset) else $error("scan reset wrong");

	property p_skip;
		startIdle && pend_ff.softPowerdown && pend_ff.scanEnable && !scanStart
			|=> (scanPos_ff == $past(scanPos_ff) + `ACS_POS_STEP);
	endproperty
	a_skip: assert property (p_skip) else $error("scan channel not skipped");

	property p_commit;
		(state_ff == ACS_FRAME) && frameEnd && (rxCnt_ff == `ACS_WORD_FULL)
			|=> (pend_ff == acs_ctrl_t'($past(rxShift_ff))) ##1 (state_ff == ACS_IDLE);
	endproperty
	a_commit: assert property (p_commit) else $error("word not committed");
endmodule

`default_nettype wire

//--- acs_host_model.sv
// Host serial port model that writes one control word per frame
`timescale 1ns/1ps
`default_nettype none

module acs_host_model (
	input wire logic clk,
	output logic sclk,
	output logic csN,
	output logic serialDataIn,
	input wire logic serialDataOut,
	input wire logic serialDataOutOe
);
	localparam int HALF = 10;
	logic sdoSeen;

	// Released pin reads as the inverse of serialDataOut, which the sequencer holds low while released
	assign sdoSeen = serialDataOutOe ? serialDataOut : !serialDataOut;

	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		serialDataIn = 1'b0;
	end

	task automatic hw();
		repeat (HALF) @(negedge clk);
	endtask

	// =============================================
	// Frame: sclk runs only while selected
	task automatic xfer(input logic [15:0] w, output logic [15:0] rx, output logic oe);
		rx = 16'h0000;
		@(negedge clk);
		csN = 1'b0;
		hw();
		oe = serialDataOutOe;
		for (int i = 15; i >= 0; i--) begin
			serialDataIn = w[i];
			hw();
			if (i < 15) begin
				rx = {rx[14:0], sdoSeen};
			end
			sclk = 1'b1;
			hw();
			sclk = 1'b0;
		end
		hw();
		rx = {rx[14:0], sdoSeen};
		csN = 1'b1;
		serialDataIn = ~serialDataIn;
		repeat (6) @(negedge clk);
	endtask
endmodule

`default_nettype wire

//--- adc_control_word_sequencer_tb_top.sv
// Self-checking testbench of the control-word sequencer
`timescale 1ns/1ps
`default_nettype none

module adc_control_word_sequencer_tb_top;
	import acs_pkg::*;
	logic clk, arst_n, sclk, csN, serialDataIn, serialDataOut, serialDataOutOe;
	logic sampleReq, frameValid, adcValid, adcReady, feed;
	logic [2:0] sampleChan;
	logic [9:0] adcData;
	acs_ctrl_t settings;
	logic [15:0] w1 = 16'h0000;
	logic [15:0] w2 = 16'h0000;
	logic [15:0] ex1 [5] = '{16'h0040, 16'h01C0, 16'h0040, 16'h8040, 16'h0040};
	logic [9:0] q [$];
	int fails = 0;
	int check_count = 0;
	int frameNo = 0;
	int pos = 0;
	int reqCnt = 0;

	acs_sequencer i_acs_sequencer (.clk(clk), .arst_n(arst_n), .sclk(sclk), .csN(csN),
		.serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
		.serialDataOutOe(serialDataOutOe), .sampleReq(sampleReq), .sampleChan(sampleChan),
		.frameValid(frameValid), .settings(settings), .adcValid(adcValid),
		.adcData(adcData), .adcReady(adcReady));
	acs_host_model i_acs_host_model (.clk(clk), .sclk(sclk), .csN(csN),
		.serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
		.serialDataOutOe(serialDataOutOe));

	initial clk = 1'b0;
	always #2 clk = ~clk;
	always @(posedge clk) if (sampleReq === 1'b1) reqCnt++;

	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic push(input logic [9:0] d);
		int n;
		n = 0;
		@(negedge clk);
		adcValid = 1'b1;
		adcData = d;
		while (adcReady !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		adcValid = 1'b0;
		if (n < 50) q.push_back(d);
		else cmp("adcReadyWait", 16'h1, 16'(adcReady));
	endtask

	// =============================================
	// Reference model of one frame
	task automatic frame(input logic [15:0] w);
		logic [15:0] rx;
		logic oe, expV;
		logic [2:0] ch;
		logic [9:0] d;
		frameNo++;
		expV = frameNo > 2 && !w1[15] && !w2[15];
		ch = w1[9:7];
		if (w1[10]) begin
			if (w1[7] || !w2[10] || w1[9:8] != w2[9:8]) pos = 0;
			case (w1[9:8])
				2'h0: ch = 3'(pos);
				2'h1: ch = 3'(2 * pos + 1);
				2'h2: ch = 3'(2 * pos);
				default: ch = 3'(7 - pos);
			endcase
			if (expV || w1[15]) pos = (pos + 1) % 8;
		end
		reqCnt = 0;
		fork
			i_acs_host_model.xfer(w, rx, oe);
			begin
				repeat (8) @(negedge clk);
				if (feed && expV) push(10'($urandom));
			end
		join
		d = 10'h000;
		if (expV && q.size() > 0) d = q.pop_front();
		cmp("settings", w1, 16'(settings));
		cmp("frameValid", 16'(expV), 16'(frameValid));
		cmp("sampleReq", 16'(expV), 16'(reqCnt));
		if (expV) cmp("sampleChan", 16'(ch), 16'(sampleChan));
		cmp("serialDataOut", 16'(d), rx);
		cmp("oeInFrame", 16'h1, 16'(oe));
		cmp("oeIdle", 16'h0, 16'(serialDataOutOe));
		cmp("sdoIdle", 16'h0, 16'(serialDataOut));
		w2 = w1;
		w1 = w;
	endtask

	task automatic many(input logic [15:0] w, input int n);
		repeat (n) frame(w);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// =============================================
	// Main sequence and watchdog
	initial begin
		#200000;
		fails++;
		wrap_up();
	end

	initial begin
		arst_n = 1'b0;
		adcValid = 1'b0;
		adcData = 10'h000;
		feed = 1'b1;
		void'($urandom(58));
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		repeat (10) @(negedge clk);
		foreach (ex1[k]) frame(ex1[k]);
		repeat (200) @(negedge clk);
		frame(16'h0140);
		frame(16'h0040);
		$display("test powerdown done");
		for (int k = 0; k < 4; k++) frame({6'h00, 3'($urandom), 4'($urandom), 3'h0});
		$display("test direct done");
		feed = 1'b0;
		push(10'($urandom));
		push(10'($urandom));
		@(negedge clk);
		cmp("adcReady", 16'h0, 16'(adcReady));
		many(16'h0040, 3);
		feed = 1'b1;
		$display("test buffer done");
		many(16'h0480, 2);
		many(16'h0400, 9);
		many(16'h0700, 3);
		many(16'h0500, 5);
		many(16'h0600, 2);
		many(16'h8600, 1);
		many(16'h0600, 1);
		repeat (200) @(negedge clk);
		many(16'h0600, 3);
		many(16'h0480, 1);
		many(16'h0400, 2);
		$display("test scan done");
		wrap_up();
	end
endmodule

`default_nettype wire
